/* File: rtl/pivu_ctrl.sv */
`timescale 1ns/100ps
`include "pivu_defs.svh"
// Functional notes
// - post only highest pending enabled request
// - core acknowledges with level in address
// - return vector number each acknowledge
// - core saves status, enters supervisor
// - core stacks state, jumps via vector
// - strictly higher level preempts running handler
// - lower or equal level waits
// - software orders same level, ends rte
// - one vector per level one to seven
// - vector is five programmed, three level
// - low bits binary level, upper from register
// - software keeps vectors in user range
// - masked sources still visible as pending
// - edge requests cleared by writing one
// - level requests held until source removes
// - unprogrammed register returns vector 0x0f
// - register bits 7..3 programmable, low reserved
// - software programs register before enabling
// - core multiplies vector by four
// - bus error gives spurious vector 24
module pivu_ctrl #(
    parameter int NEXT = `PIVU_NUM_EXT,
    parameter int NINT = 8
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    // link to core
    pivu_if.ctrl                        lnk,
    // source pins and peripheral levels
    input  wire logic [NEXT-1:0]        ext_pin,
    input  wire logic [NEXT-1:0]        ext_edge_sel,
    input  wire logic [NEXT-1:0]        ext_pol,
    input  wire logic [NEXT*3-1:0]      ext_lvl_map,
    input  wire logic [NINT-1:0]        int_req,
    input  wire logic [NINT*3-1:0]      int_lvl_map,
    // software register access
    input  wire logic                   vbr_wr,
    input  wire pivu_pkg::pivu_vector_t vbr_wdata,
    input  wire logic [NEXT+NINT-1:0]   mask_bits,
    input  wire logic                   status_clr_wr,
    input  wire logic [NEXT-1:0]        status_clr_bits,
    output pivu_pkg::pivu_vector_t      vbr_rdata,
    output logic [NEXT+NINT-1:0]        pending_flags_register,
    output logic [NEXT+NINT-1:0]        interrupt_status_register
);
    localparam int NSRC = NEXT + NINT;

    // three-stage pin synchroniser
    logic [NEXT-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
    logic [NEXT-1:0] ext_lvl_q, ext_lvl_d, edge_q, edge_d;
    logic [1:0]      fill_q, fill_d;
    logic [7:0]      vbr_q, vbr_d;
    logic            vbr_set_q, vbr_set_d;
    logic [NSRC-1:0] pend_q, pend_d, stat_q, stat_d;
    logic            post_q, post_d, done_q, done_d;
    pivu_pkg::pivu_level_t  lvl_q, lvl_d;
    pivu_pkg::pivu_vector_t vec_q, vec_d;
    pivu_pkg::pivu_ack_state_t st_q, st_d;

    logic [NSRC-1:0]   raw;
    logic [NSRC*3-1:0] map;
    logic [6:0]        lvl_req;
    pivu_pkg::pivu_level_t top;

    function automatic logic [6:0] lvl_onehot(input logic [2:0] l);
        lvl_onehot = (l == 3'h0) ? 7'h00 : 7'(7'h01 << (l - 3'h1));
    endfunction

    // a pin counts once stages two and three agree; levels stay inactive
    // until the chain holds real samples, so reset zeros never fake an edge
    always_comb
    begin
        s1_d = ext_pin;
        s2_d = s1_q;
        s3_d = s2_q;
        fill_d = (fill_q == `PIVU_SYNC_FILL) ? fill_q : 2'(fill_q + 2'h1);
        ext_lvl_d = ext_lvl_q;
        for (int i = 0; i < NEXT; i++)
            if (fill_q == `PIVU_SYNC_FILL && s2_q[i] == s3_q[i])
                ext_lvl_d[i] = s3_q[i] ~^ ext_pol[i];
    end

    // edge latches: set by active edge, cleared by writing one; set wins
    always_comb
    begin
        edge_d = edge_q;
        for (int i = 0; i < NEXT; i++)
        begin
            if (status_clr_wr && status_clr_bits[i])
                edge_d[i] = 1'b0;
            if (ext_edge_sel[i] && ext_lvl_d[i] && !ext_lvl_q[i])
                edge_d[i] = 1'b1;
        end
    end

    // raw sources: edge latch or live level
    always_comb
    begin
        for (int i = 0; i < NEXT; i++)
            raw[i] = ext_edge_sel[i] ? edge_q[i] : ext_lvl_q[i];
        raw[NSRC-1:NEXT] = int_req;
        map = {int_lvl_map, ext_lvl_map};
    end

    // pending shows all sources; status shows unmasked ones
    always_comb
    begin
        pend_d = raw;
        stat_d = raw & ~mask_bits;
        lvl_req = 7'h00;
        for (int i = 0; i < NSRC; i++)
            if (stat_q[i])
                lvl_req = lvl_req | lvl_onehot(map[i*3 +: 3]);
    end

    pivu_prio_enc #(.LEVELS(`PIVU_NUM_LEVELS)) u_enc (
        .level_req (lvl_req),
        .top_level (top)
    );

    // vector register; reserved low bits read zero
    always_comb
    begin
        vbr_d = vbr_q;
        vbr_set_d = vbr_set_q;
        if (vbr_wr)
        begin
            vbr_d = {vbr_wdata[`PIVU_VBR_UPPER_MSB:`PIVU_VBR_UPPER_LSB], 3'h0};
            vbr_set_d = 1'b1;
        end
    end

    // posting and acknowledge answer
    always_comb
    begin
        st_d = st_q;
        post_d = (top != 3'h0);
        lvl_d = top;
        done_d = 1'b0;
        vec_d = vec_q;
        case (st_q)
            pivu_pkg::PIVU_ACK_IDLE:
                if (lnk.ack_req)
                    st_d = pivu_pkg::PIVU_ACK_WAIT;
            pivu_pkg::PIVU_ACK_WAIT:
            begin
                done_d = 1'b1;
                if (lnk.bus_err)
                    vec_d = `PIVU_VEC_SPURIOUS;
                else if (!vbr_set_q)
                    vec_d = `PIVU_VEC_UNINIT;
                else
                    vec_d = {vbr_q[7:3], lnk.ack_addr};
                st_d = pivu_pkg::PIVU_ACK_DONE;
            end
            pivu_pkg::PIVU_ACK_DONE:
                if (!lnk.ack_req)
                    st_d = pivu_pkg::PIVU_ACK_IDLE;
            default:
                st_d = pivu_pkg::PIVU_ACK_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            fill_q <= 2'h0;
            ext_lvl_q <= '0;
            edge_q <= '0;
            vbr_q <= `PIVU_VBR_RESET;
            vbr_set_q <= 1'b0;
            pend_q <= '0;
            stat_q <= '0;
            post_q <= 1'b0;
            lvl_q <= 3'h0;
            done_q <= 1'b0;
            vec_q <= `PIVU_VEC_UNINIT;
            st_q <= pivu_pkg::PIVU_ACK_IDLE;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            fill_q <= fill_d;
            ext_lvl_q <= ext_lvl_d;
            edge_q <= edge_d;
            vbr_q <= vbr_d;
            vbr_set_q <= vbr_set_d;
            pend_q <= pend_d;
            stat_q <= stat_d;
            post_q <= post_d;
            lvl_q <= lvl_d;
            done_q <= done_d;
            vec_q <= vec_d;
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign lnk.irq_post   = post_q;
    assign lnk.irq_level  = lvl_q;
    assign lnk.ack_done   = done_q;
    assign lnk.ack_vector = vec_q;
    assign vbr_rdata      = vbr_q;
    assign pending_flags_register    = pend_q;
    assign interrupt_status_register = stat_q;
endmodule

/* File: rtl/pivu_defs.svh */
`ifndef PIVU_DEFS_SVH
`define PIVU_DEFS_SVH

// vector register layout
`define PIVU_VBR_RESET      8'h00
`define PIVU_VBR_UPPER_MSB  7
`define PIVU_VBR_UPPER_LSB  3
// fixed vector numbers
`define PIVU_VEC_UNINIT     8'h0f
`define PIVU_VEC_SPURIOUS   8'h18
// level count and source groups
`define PIVU_NUM_LEVELS     7
`define PIVU_NUM_EXT        8
// synchroniser fill count before a pin is trusted
`define PIVU_SYNC_FILL      2'h3

`endif

/* File: rtl/pivu_pkg.sv */
package pivu_pkg;
    typedef logic [2:0] pivu_level_t;
    typedef logic [7:0] pivu_vector_t;
    typedef enum logic [1:0] {PIVU_ACK_IDLE, PIVU_ACK_WAIT, PIVU_ACK_DONE} pivu_ack_state_t;
endpackage

/* File: rtl/pivu_if.sv */
`timescale 1ns/100ps
interface pivu_if;
    logic                 irq_post;
    pivu_pkg::pivu_level_t irq_level;
    logic                 ack_req;
    pivu_pkg::pivu_level_t ack_addr;
    logic                 ack_done;
    pivu_pkg::pivu_vector_t ack_vector;
    logic                 bus_err;

    modport ctrl (output irq_post, output irq_level, input ack_req, input ack_addr,
                  output ack_done, output ack_vector, input bus_err);
    modport core (input irq_post, input irq_level, output ack_req, output ack_addr,
                  input ack_done, input ack_vector, output bus_err);
endinterface

/* File: rtl/pivu_prio_enc.sv */
`timescale 1ns/100ps
`include "pivu_defs.svh"
module pivu_prio_enc #(
    parameter int LEVELS = `PIVU_NUM_LEVELS
) (
    // per-level request, bit 0 is level 1
    input  wire logic [LEVELS-1:0]     level_req,
    // highest level, zero when none
    output pivu_pkg::pivu_level_t      top_level
);
    // scan from low to high so the highest level wins
    always_comb
    begin
        top_level = 3'h0;
        for (int i = 0; i < LEVELS; i++)
            if (level_req[i])
                top_level = 3'(i + 1);
    end
endmodule

/* File: rtl/pivu_core_end.sv */
`timescale 1ns/100ps
`include "pivu_defs.svh"
module pivu_core_end (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               srst,
    // link to controller
    pivu_if.core                    lnk,
    // user side
    input  wire logic               bus_err_in,
    input  wire logic               rte,
    output pivu_pkg::pivu_level_t   run_level,
    output logic                    supervisor,
    output logic [9:0]              vec_addr,
    output logic                    vec_valid
);
    localparam int DEPTH = `PIVU_NUM_LEVELS;

    logic        req_q, req_d, sup_q, sup_d, vv_q, vv_d, err_q, err_d;
    logic [2:0]  addr_q, addr_d, run_q, run_d, sp_q, sp_d, sav_top;
    logic [2:0]  stk_q [DEPTH];
    logic [2:0]  stk_d [DEPTH];
    logic [9:0]  va_q, va_d;

    // take interrupt only above running level; save and enter supervisor.
    // levels only climb while nesting, so one saved entry per level suffices
    always_comb
    begin
        req_d = req_q;
        addr_d = addr_q;
        run_d = run_q;
        sp_d = sp_q;
        stk_d = stk_q;
        sup_d = sup_q;
        va_d = va_q;
        vv_d = 1'b0;
        err_d = bus_err_in;
        sav_top = (sp_q != 3'h0) ? stk_q[3'(sp_q - 3'h1)] : 3'h0;
        if (!req_q && lnk.irq_post && lnk.irq_level > run_q)
        begin
            stk_d[sp_q] = run_q;
            sp_d = 3'(sp_q + 3'h1);
            sup_d = 1'b1;
            req_d = 1'b1;
            addr_d = lnk.irq_level;
        end
        else if (req_q && lnk.ack_done)
        begin
            req_d = 1'b0;
            run_d = addr_q;
            va_d = {lnk.ack_vector, 2'b00};
            vv_d = 1'b1;
        end
        else if (!req_q && rte && sp_q != 3'h0)
        begin
            sp_d = 3'(sp_q - 3'h1);
            run_d = sav_top;
            sup_d = (sav_top != 3'h0);
        end
    end

    // state registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            req_q <= 1'b0;
            addr_q <= 3'h0;
            run_q <= 3'h0;
            sp_q <= 3'h0;
            stk_q <= '{default: 3'h0};
            sup_q <= 1'b1;
            va_q <= 10'h000;
            vv_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            req_q <= req_d;
            addr_q <= addr_d;
            run_q <= run_d;
            sp_q <= sp_d;
            stk_q <= stk_d;
            sup_q <= sup_d;
            va_q <= va_d;
            vv_q <= vv_d;
            err_q <= err_d;
        end
    end

    assign lnk.ack_req  = req_q;
    assign lnk.ack_addr = addr_q;
    assign lnk.bus_err  = err_q;
    assign run_level    = run_q;
    assign supervisor   = sup_q;
    assign vec_addr     = va_q;
    assign vec_valid    = vv_q;
endmodule

/* File: tb/pivu_chk.sv */
`timescale 1ns/100ps
module pivu_chk (
    // clock and reset
    input wire logic                   sys_clk,
    input wire logic                   srst,
    // link signals
    input wire logic                   irq_post,
    input wire pivu_pkg::pivu_level_t  irq_level,
    input wire logic                   ack_req,
    input wire pivu_pkg::pivu_level_t  ack_addr,
    input wire logic                   ack_done,
    input wire pivu_pkg::pivu_vector_t ack_vector,
    input wire logic                   bus_err
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // handshake timing; a stuck ack would also re-vector
    property p_lat; $rose(ack_req) |-> ##2 ack_done; endproperty
    a_lat: assert property (p_lat) else $error("ack late");
    property p_gap; ack_done |=> !ack_done [*3]; endproperty
    a_gap: assert property (p_gap) else $error("ack repeated");
    property p_req; ack_done |-> ack_req && $past(ack_req, 2); endproperty
    a_req: assert property (p_req) else $error("unasked ack");
    property p_addr; ack_req && $past(ack_req) |-> $stable(ack_addr); endproperty
    a_addr: assert property (p_addr) else $error("ack level moved");
    // vector contents and posted level
    property p_spur; ack_done && $past(bus_err) |-> ack_vector == 8'h18; endproperty
    a_spur: assert property (p_spur) else $error("not spurious");
    property p_pair; ack_done && !$past(bus_err) |-> ack_vector == 8'h0f || ack_vector[2:0] == ack_addr; endproperty
    a_pair: assert property (p_pair) else $error("low bits wrong");
    property p_hold; !ack_done |-> $stable(ack_vector); endproperty
    a_hold: assert property (p_hold) else $error("vector moved");
    property p_post; irq_post |-> irq_level != 3'h0; endproperty
    a_post: assert property (p_post) else $error("post without level");
    // main scenarios reached
    c_spur: cover property (ack_done && $past(bus_err));
    c_uninit: cover property (ack_done && ack_vector == 8'h0f);
    c_nest: cover property (ack_done ##[4:60] ack_done);
endmodule

/* File: tb/priority_interrupt_vector_unit_tb_top.sv */
`timescale 1ns/100ps
module priority_interrupt_vector_unit_tb_top;
    logic                   sys_clk, srst, vbr_wr, status_clr_wr, bus_err_in, rte, supervisor, vec_valid;
    logic [7:0]             ext_pin, ext_edge_sel, ext_pol, int_req, status_clr_bits;
    logic [23:0]            ext_lvl_map, int_lvl_map;
    logic [15:0]            mask_bits, pend, stat;
    pivu_pkg::pivu_vector_t vbr_wdata, vbr_rdata, vb;
    pivu_pkg::pivu_level_t  run_level;
    logic [9:0]             vec_addr;
    int                     num_errors = 0;
    int                     cmp_count = 0;
    pivu_if lnk_if();
    pivu_ctrl pivu_ctrl_inst (.sys_clk(sys_clk), .srst(srst), .lnk(lnk_if), .ext_pin(ext_pin),
        .ext_edge_sel(ext_edge_sel), .ext_pol(ext_pol), .ext_lvl_map(ext_lvl_map), .int_req(int_req),
        .int_lvl_map(int_lvl_map), .vbr_wr(vbr_wr), .vbr_wdata(vbr_wdata), .mask_bits(mask_bits),
        .status_clr_wr(status_clr_wr), .status_clr_bits(status_clr_bits), .vbr_rdata(vbr_rdata),
        .pending_flags_register(pend), .interrupt_status_register(stat));
    pivu_core_end pivu_core_end_inst (.sys_clk(sys_clk), .srst(srst), .lnk(lnk_if), .bus_err_in(bus_err_in),
        .rte(rte), .run_level(run_level), .supervisor(supervisor), .vec_addr(vec_addr), .vec_valid(vec_valid));
    pivu_chk pivu_chk_inst (.sys_clk(sys_clk), .srst(srst), .irq_post(lnk_if.irq_post),
        .irq_level(lnk_if.irq_level), .ack_req(lnk_if.ack_req), .ack_addr(lnk_if.ack_addr),
        .ack_done(lnk_if.ack_done), .ack_vector(lnk_if.ack_vector), .bus_err(lnk_if.bus_err));
    // free-running system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    function automatic pivu_pkg::pivu_vector_t exp_vec(pivu_pkg::pivu_vector_t b, int l);
        return {b[7:3], 3'(l)};
    endfunction
    task automatic summarize;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string name, logic [15:0] seen, logic [15:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, want, seen);
        end
    endtask
    // inputs move 1 ns after the edge, clear of sampling
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // bounded wait for the core to vector; want=0 means it must stay quiet
    task automatic vec(pivu_pkg::pivu_vector_t v, logic want);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 40 && !hit; i++)
        begin
            cyc(1);
            hit = (vec_valid === 1'b1);
        end
        chk("vec_valid", 16'(hit), 16'(want));
        if (hit)
        begin
            chk("vec_addr", 16'(vec_addr), {6'h00, v, 2'b00});
            chk("supervisor", 16'(supervisor), 16'h0001);
        end
    endtask
    // drop requests first, or an rte would re-take a stale post
    task automatic quiet;
        int_req = 8'h00;
        status_clr_wr = 1'b1;
        status_clr_bits = 8'hff;
        cyc(1);
        status_clr_wr = 1'b0;
        cyc(10);
        repeat (3)
        begin
            rte = 1'b1;
            cyc(1);
            rte = 1'b0;
            cyc(1);
        end
        cyc(4);
        chk("run_level", 16'(run_level), 16'h0000);
    endtask
    // watchdog: the sequence needs well under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        summarize();
    end
    initial
    begin
        int s;
        void'($urandom(32'hf39fedd2));
        {srst, vbr_wr, status_clr_wr, bus_err_in, rte} = 5'h10;
        {ext_pin, ext_edge_sel, int_req, status_clr_bits, vbr_wdata} = '0;
        {ext_lvl_map, int_lvl_map, mask_bits} = '0;
        ext_pol = 8'hff;
        cyc(5);
        srst = 1'b0;
        cyc(1);
        // vector register never written
        int_lvl_map = 24'h000003;
        int_req = 8'h01;
        vec(8'h0f, 1'b1);
        quiet;
        // base keeps user vectors at 0x100 and up; reserved bits written zero
        vb = {5'($urandom_range(31, 8)), 3'h0};
        vbr_wdata = vb;
        vbr_wr = 1'b1;
        cyc(1);
        vbr_wr = 1'b0;
        cyc(2);
        chk("vbr_rdata", 16'(vbr_rdata), {8'h00, vb[7:3], 3'h0});
        // each level from a random peripheral
        for (int l = 1; l <= 7; l++)
        begin
            s = $urandom_range(7);
            int_lvl_map[s*3 +: 3] = 3'(l);
            int_req[s] = 1'b1;
            vec(exp_vec(vb, l), 1'b1);
            quiet;
        end
        // levels 2 and 6 together, then equal 6 waits, then 7 preempts
        int_lvl_map = 24'h000fb2;
        int_req = 8'h03;
        vec(exp_vec(vb, 6), 1'b1);
        int_req[2] = 1'b1;
        vec(8'h00, 1'b0);
        chk("run_level", 16'(run_level), 16'h0006);
        int_req[3] = 1'b1;
        vec(exp_vec(vb, 7), 1'b1);
        chk("run_level", 16'(run_level), 16'h0007);
        quiet;
        // masked source stays pending but never posts
        mask_bits = 16'h0100;
        int_lvl_map = 24'h000005;
        int_req = 8'h01;
        vec(8'h00, 1'b0);
        chk("pending", pend, 16'h0100);
        chk("status", stat, 16'h0000);
        mask_bits = 16'h0000;
        vec(exp_vec(vb, 5), 1'b1);
        chk("level held", stat, 16'h0100);
        quiet;
        chk("level gone", stat, 16'h0000);
        // rising edge latched after the pin falls, cleared by a one
        ext_edge_sel = 8'h01;
        ext_lvl_map = 24'h000004;
        ext_pin = 8'h01;
        cyc(2);
        ext_pin = 8'h00;
        vec(exp_vec(vb, 4), 1'b1);
        chk("edge latched", stat, 16'h0001);
        quiet;
        chk("edge cleared", stat, 16'h0000);
        // bus error during the acknowledge
        bus_err_in = 1'b1;
        int_req = 8'h01;
        vec(8'h18, 1'b1);
        bus_err_in = 1'b0;
        quiet;
        // mid-run reset, idle-high active-low edge pin must not fake an edge
        srst = 1'b1;
        ext_pol = 8'hfd;
        ext_pin = 8'h02;
        ext_edge_sel = 8'h02;
        ext_lvl_map = 24'h000030;
        cyc(5);
        srst = 1'b0;
        vec(8'h00, 1'b0);
        chk("no false edge", stat, 16'h0000);
        chk("vbr reset", 16'(vbr_rdata), 16'h0000);
        // same pin as an active-low level; register unprogrammed again
        ext_edge_sel = 8'h00;
        ext_pin = 8'h00;
        vec(8'h0f, 1'b1);
        chk("low level", stat, 16'h0002);
        ext_pin = 8'h02;
        quiet;
        chk("low level gone", stat, 16'h0000);
        summarize();
    end
endmodule
